// ==== design/eau_top.sv ====
// effective address unit: specifier decode, address forming, control registers
`timescale 1ns/1ps
module eau_top (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic START,
	input wire logic [15:0] OP_WORD,
	input wire logic [1:0] OP_SIZE,
	input wire logic OP_JUMP,
	input wire logic OP_WRITE,
	input wire logic OP_ALT_MOVE,
	input wire logic OP_STATUS_OK,
	input wire logic SUPERVISOR,
	output logic EXT_REQ,
	input wire logic EXT_VALID,
	input wire logic [15:0] EXT_WORD,
	input wire logic [31:0] EXT_PC,
	output logic [3:0] RF_SEL,
	input wire logic [31:0] RF_DATA,
	output logic DONE,
	output logic [1:0] EXT_COUNT,
	output logic [31:0] EA_ADDR,
	output logic [31:0] EA_DATA,
	output logic EA_IS_REG,
	output logic EA_IS_IMM,
	output logic EA_STATUS,
	output logic EA_PROGRAM,
	output logic EA_INVALID,
	output logic EA_MISALIGNED,
	output logic LANE_UPPER,
	output logic LANE_LOWER,
	output logic [2:0] SPACE_CODE,
	output logic AN_WB,
	output logic [2:0] AN_NUM,
	output logic [31:0] AN_NEW,
	input wire logic CREG_WR,
	input wire logic [1:0] CREG_SEL,
	input wire logic [31:0] CREG_WDATA,
	output logic [31:0] CREG_RDATA
);
	// **********
	// state record
	// **********
	typedef struct packed {
		eau_pkg::eau_state_t st; // sequencing state
		logic [2:0] mode; // captured mode field
		logic [2:0] regf; // captured register field
		logic [1:0] size; // operand size
		logic jump; // jump or subroutine call
		logic wr; // operand write
		logic alt; // alternate space move
		logic stok; // status word target allowed
		logic sup; // supervisor state
		logic inval; // invalid specifier
		logic [1:0] need; // extension words needed
		logic [1:0] got; // extension words taken
		logic [15:0] ext1; // first extension word
		logic [15:0] ext2; // second extension word
		logic [31:0] xpc; // address of first extension word
		logic [31:0] base; // base register value
		logic [31:0] idx; // index contribution
		logic [3:0] rf_sel; // register file select
		logic ext_req; // asking for an extension word
		logic done; // result pulse
		logic [1:0] ext_cnt; // reported extension count
		logic [31:0] addr; // operand address
		logic [31:0] data; // operand value
		logic is_reg; // operand is a register
		logic is_imm; // operand is immediate
		logic is_st; // operand is status word
		logic prog; // program space reference
		logic misal; // odd word or long address
		logic lane_u; // upper byte lane
		logic lane_l; // lower byte lane
		logic [2:0] sc; // space code pins
		logic an_wb; // address register update pulse
		logic [31:0] an_new; // updated address register
		logic [31:0] vtb; // vector table base
		logic [2:0] ssc; // source space code
		logic [2:0] dsc; // dest space code
		logic [31:0] crd; // control register read data
	} eau_rec_t;

	eau_rec_t cur_reg; // registered state
	eau_rec_t cur_next; // next state
	logic rst_meta_n_reg; // reset synchroniser first stage
	logic rst_n_reg; // synchronised reset
	logic [2:0] dec_mode; // decoded mode
	logic [2:0] dec_regf; // decoded register field
	logic [1:0] dec_ext; // decoded extension count
	logic dec_inval; // decoded invalid flag

	// **********
	// reset release
	// **********
	// two stages so the release meets the clock cleanly
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_n_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_n_reg <= 1'b1;
			rst_n_reg <= rst_meta_n_reg;
		end
	end

	// **********
	// specifier decoder
	// **********
	eau_spec_decode u_dec (
		.spec(OP_WORD[5:0]),
		.size(OP_SIZE),
		.mode(dec_mode),
		.regf(dec_regf),
		.ext_words(dec_ext),
		.invalid(dec_inval)
	);

	// index select bits in the extension word
	localparam int EAU_XSEL_HI = eau_pkg::EAU_X_DA;
	localparam int EAU_XSEL_LO = eau_pkg::EAU_X_DA - 3;

	// **********
	// next state logic
	// **********
	// sequence: capture, read base, take extensions, read index, finish
	always_comb begin
		logic [31:0] step;
		logic [31:0] disp8;
		logic [31:0] disp16;
		logic [31:0] a;
		logic mem;
		logic pcrel;
		step = eau_pkg::EAU_STEP_B;
		disp8 = 32'h0;
		disp16 = 32'h0;
		a = 32'h0;
		mem = 1'b0;
		pcrel = 1'b0;
		cur_next = cur_reg;
		cur_next.done = 1'b0;
		cur_next.an_wb = 1'b0;
		// control register alternate_space_move, always full long word, see RL1
		if (CREG_WR) begin
			case (CREG_SEL)
				eau_pkg::EAU_CR_VTB: cur_next.vtb = CREG_WDATA; // see RL1
				eau_pkg::EAU_CR_SSC: cur_next.ssc = CREG_WDATA[2:0]; // upper bits dropped, see RL2
				eau_pkg::EAU_CR_DSC: cur_next.dsc = CREG_WDATA[2:0]; // see RL2
				default: cur_next.vtb = cur_reg.vtb; // unused select ignored
			endcase
		end
		// read data follows the select, vector base whole, space code upper bits zero, see RL2
		case (CREG_SEL)
			eau_pkg::EAU_CR_VTB: cur_next.crd = cur_reg.vtb; // see RL1
			eau_pkg::EAU_CR_SSC: cur_next.crd = {29'h0, cur_reg.ssc}; // see RL2
			eau_pkg::EAU_CR_DSC: cur_next.crd = {29'h0, cur_reg.dsc}; // see RL2
			default: cur_next.crd = 32'h0; // unused select reads zero
		endcase
		case (cur_reg.st)
			eau_pkg::EAU_IDLE: begin
				// capture the operation word fields
				if (START) begin
					cur_next.mode = dec_mode;
					cur_next.regf = dec_regf;
					cur_next.size = OP_SIZE;
					cur_next.jump = OP_JUMP;
					cur_next.wr = OP_WRITE;
					cur_next.alt = OP_ALT_MOVE;
					cur_next.stok = OP_STATUS_OK;
					cur_next.sup = SUPERVISOR;
					cur_next.inval = dec_inval;
					cur_next.need = dec_ext; // see RL6
					cur_next.got = 2'h0;
					cur_next.ext1 = 16'h0;
					cur_next.ext2 = 16'h0;
					cur_next.idx = 32'h0;
					// data registers 0-7, address registers 8-15, see RL9
					cur_next.rf_sel = {(dec_mode != eau_pkg::EAU_M_DREG), dec_regf};
					if (dec_inval) begin
						cur_next.st = eau_pkg::EAU_FIN; // no address formed, see RL25
					end else begin
						cur_next.st = eau_pkg::EAU_RBASE;
					end
				end
			end
			eau_pkg::EAU_RBASE: begin
				// register file answers one cycle after the select
				cur_next.base = RF_DATA;
				if (cur_reg.need != 2'h0) begin
					cur_next.ext_req = 1'b1;
					cur_next.st = eau_pkg::EAU_EXTW;
				end else begin
					cur_next.st = eau_pkg::EAU_FIN;
				end
			end
			eau_pkg::EAU_EXTW: begin
				// take extension words in stream order
				if (EXT_VALID) begin
					cur_next.got = cur_reg.got + 2'h1;
					if (cur_reg.got == 2'h0) begin
						cur_next.ext1 = EXT_WORD;
						cur_next.xpc = EXT_PC; // see RL18
					end else begin
						cur_next.ext2 = EXT_WORD;
					end
					if (cur_reg.got + 2'h1 == cur_reg.need) begin
						cur_next.ext_req = 1'b0;
						// index register named by the extension word, see RL14
						if (cur_reg.mode == eau_pkg::EAU_M_INDEX ||
							(cur_reg.mode == eau_pkg::EAU_M_SPEC && cur_reg.regf == eau_pkg::EAU_S_PCX)) begin
							cur_next.rf_sel = EXT_WORD[EAU_XSEL_HI:EAU_XSEL_LO];
							cur_next.st = eau_pkg::EAU_RIDX;
						end else begin
							cur_next.st = eau_pkg::EAU_FIN;
						end
					end
				end
			end
			eau_pkg::EAU_RIDX: begin
				// word index is sign extended, long taken whole, see RL15
				if (cur_reg.ext1[eau_pkg::EAU_X_LONG]) begin
					cur_next.idx = RF_DATA;
				end else begin
					cur_next.idx = {{16{RF_DATA[15]}}, RF_DATA[15:0]};
				end
				cur_next.st = eau_pkg::EAU_FIN;
			end
			eau_pkg::EAU_FIN: begin
				disp8 = {{24{cur_reg.ext1[7]}}, cur_reg.ext1[7:0]};
				disp16 = {{16{cur_reg.ext1[15]}}, cur_reg.ext1};
				// stack pointer keeps word alignment on byte steps
				case (cur_reg.size)
					eau_pkg::EAU_SZ_BYTE: begin
						step = (cur_reg.regf == eau_pkg::EAU_SP_REG) ? eau_pkg::EAU_STEP_W : eau_pkg::EAU_STEP_B;
					end
					eau_pkg::EAU_SZ_WORD: step = eau_pkg::EAU_STEP_W;
					default: step = eau_pkg::EAU_STEP_L;
				endcase
				cur_next.is_reg = 1'b0;
				cur_next.is_imm = 1'b0;
				cur_next.is_st = 1'b0;
				cur_next.data = 32'h0;
				cur_next.an_new = cur_reg.base;
				case (cur_reg.mode)
					eau_pkg::EAU_M_DREG: begin
						cur_next.is_reg = 1'b1; // see RL9
						cur_next.data = cur_reg.base;
					end
					eau_pkg::EAU_M_AREG: begin
						cur_next.is_reg = 1'b1; // see RL9
						// word operand widened for the whole register, see RL24
						if (cur_reg.size == eau_pkg::EAU_SZ_WORD) begin
							cur_next.data = {{16{cur_reg.base[15]}}, cur_reg.base[15:0]};
						end else begin
							cur_next.data = cur_reg.base;
						end
					end
					eau_pkg::EAU_M_IND: begin
						a = cur_reg.base;
						mem = 1'b1;
					end
					eau_pkg::EAU_M_POST: begin
						a = cur_reg.base; // see RL11
						cur_next.an_new = cur_reg.base + step; // see RL11
						cur_next.an_wb = 1'b1;
						mem = 1'b1;
					end
					eau_pkg::EAU_M_PRE: begin
						a = cur_reg.base - step; // see RL12
						cur_next.an_new = cur_reg.base - step; // see RL12
						cur_next.an_wb = 1'b1;
						mem = 1'b1;
					end
					eau_pkg::EAU_M_DISP: begin
						a = cur_reg.base + disp16; // see RL13
						mem = 1'b1;
					end
					eau_pkg::EAU_M_INDEX: begin
						a = cur_reg.base + disp8 + cur_reg.idx; // see RL14
						mem = 1'b1;
					end
					default: begin
						// register field picks the sub-mode, see RL21
						case (cur_reg.regf)
							eau_pkg::EAU_S_ABSS: begin
								a = disp16; // see RL16
								mem = 1'b1;
							end
							eau_pkg::EAU_S_ABSL: begin
								a = {cur_reg.ext1, cur_reg.ext2}; // see RL17
								mem = 1'b1;
							end
							eau_pkg::EAU_S_PCD: begin
								a = cur_reg.xpc + disp16; // see RL18
								pcrel = 1'b1;
							end
							eau_pkg::EAU_S_PCX: begin
								a = cur_reg.xpc + disp8 + cur_reg.idx; // see RL18
								pcrel = 1'b1;
							end
							eau_pkg::EAU_S_IMM: begin
								if (cur_reg.stok) begin
									cur_next.is_st = 1'b1; // see RL22
								end else begin
									cur_next.is_imm = 1'b1; // see RL20
								end
								case (cur_reg.size)
									eau_pkg::EAU_SZ_BYTE: cur_next.data = {24'h0, cur_reg.ext1[7:0]}; // see RL20
									eau_pkg::EAU_SZ_WORD: cur_next.data = {16'h0, cur_reg.ext1}; // see RL20
									default: cur_next.data = {cur_reg.ext1, cur_reg.ext2}; // see RL20
								endcase
							end
							default: a = 32'h0; // invalid, no address, see RL25
						endcase
					end
				endcase
				cur_next.addr = a;
				// writes never go to program space, see RL7 see RL10 see RL19
				cur_next.prog = !cur_reg.wr && (pcrel || (mem && cur_reg.jump));
				// word and long accesses need even addresses, see RL5
				cur_next.misal = (mem || pcrel) && (cur_reg.size != eau_pkg::EAU_SZ_BYTE) && a[0];
				// high byte at even address, low at odd, see RL4
				if (cur_reg.size == eau_pkg::EAU_SZ_BYTE) begin
					cur_next.lane_u = !a[0];
					cur_next.lane_l = a[0];
				end else begin
					cur_next.lane_u = mem || pcrel;
					cur_next.lane_l = mem || pcrel;
				end
				// alternate alternate_space_move use the stored code, see RL3
				if (cur_reg.alt) begin
					cur_next.sc = cur_reg.wr ? cur_reg.dsc : cur_reg.ssc;
				end else begin
					cur_next.sc = {cur_reg.sup, (cur_next.prog ? eau_pkg::EAU_SC_PROG : eau_pkg::EAU_SC_DATA)};
				end
				cur_next.ext_cnt = cur_reg.need; // see RL6
				cur_next.done = 1'b1;
				cur_next.st = eau_pkg::EAU_IDLE;
			end
			default: cur_next.st = eau_pkg::EAU_IDLE; // recover from a bad code
		endcase
	end

	// **********
	// state register
	// **********
	always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			cur_reg <= '0;
			cur_reg.st <= eau_pkg::EAU_IDLE;
			cur_reg.vtb <= eau_pkg::EAU_VTB_RST;
			cur_reg.ssc <= eau_pkg::EAU_SC_RST;
			cur_reg.dsc <= eau_pkg::EAU_SC_RST;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// **********
	// outputs, all from the state register
	// **********
	assign EXT_REQ = cur_reg.ext_req;
	assign RF_SEL = cur_reg.rf_sel;
	assign DONE = cur_reg.done;
	assign EXT_COUNT = cur_reg.ext_cnt;
	assign EA_ADDR = cur_reg.addr;
	assign EA_DATA = cur_reg.data;
	assign EA_IS_REG = cur_reg.is_reg;
	assign EA_IS_IMM = cur_reg.is_imm;
	assign EA_STATUS = cur_reg.is_st;
	assign EA_PROGRAM = cur_reg.prog;
	assign EA_INVALID = cur_reg.inval;
	assign EA_MISALIGNED = cur_reg.misal;
	assign LANE_UPPER = cur_reg.lane_u;
	assign LANE_LOWER = cur_reg.lane_l;
	assign SPACE_CODE = cur_reg.sc;
	assign AN_WB = cur_reg.an_wb;
	assign AN_NUM = cur_reg.regf;
	assign AN_NEW = cur_reg.an_new;
	assign CREG_RDATA = cur_reg.crd;
endmodule // eau_top

// ==== design/eau_pkg.sv ====
// constants, codes and state type of the effective address unit
//
// What this block does
// (RL1) vector base is 32 bits, long alternate_space_move only
// (RL2) space-code registers 3 bits, upper 29 zero
// (RL3) alternate move drives stored space code out
// (RL4) high byte even address, low byte odd
// (RL5) word and long accesses only at even addresses
// (RL6) length fixed by operation word alone
// (RL7) operand writes always go to data space
// (RL8) specifier splits into mode and register fields
// (RL9) direct modes read register, no memory access
// (RL10) memory and absolute modes are data, except jumps
// (RL11) postincrement uses address then adds size step
// (RL12) predecrement subtracts size step then uses address
// (RL13) displacement adds sign-extended 16-bit extension word
// (RL14) index adds base, 8-bit displacement, index
// (RL15) index is sign-extended word or full long
// (RL16) absolute short sign-extends one extension word
// (RL17) absolute long joins two words, high first
// (RL18) program modes use extension word address as base
// (RL19) program-relative references are program space
// (RL20) immediate byte, word or two-word long operand
// (RL21) special modes use register field as sub-mode
// (RL22) selected instructions may target status word
// (RL23) mode and sub-mode code assignment
// (RL24) address register destination gets sign-extended word
// (RL25) unused special sub-modes flagged invalid
package eau_pkg;
	// **********
	// addressing mode codes
	// **********
	localparam logic [2:0] EAU_M_DREG = 3'h0; // data register direct
	localparam logic [2:0] EAU_M_AREG = 3'h1; // address register direct
	localparam logic [2:0] EAU_M_IND = 3'h2; // indirect
	localparam logic [2:0] EAU_M_POST = 3'h3; // postincrement
	localparam logic [2:0] EAU_M_PRE = 3'h4; // predecrement
	localparam logic [2:0] EAU_M_DISP = 3'h5; // displacement
	localparam logic [2:0] EAU_M_INDEX = 3'h6; // index
	localparam logic [2:0] EAU_M_SPEC = 3'h7; // special group
	localparam logic [2:0] EAU_S_ABSS = 3'h0; // absolute short
	localparam logic [2:0] EAU_S_ABSL = 3'h1; // absolute long
	localparam logic [2:0] EAU_S_PCD = 3'h2; // program counter displacement
	localparam logic [2:0] EAU_S_PCX = 3'h3; // program counter index
	localparam logic [2:0] EAU_S_IMM = 3'h4; // immediate
	localparam logic [2:0] EAU_SP_REG = 3'h7; // stack pointer number
	// **********
	// operand sizes and steps
	// **********
	localparam logic [1:0] EAU_SZ_BYTE = 2'h0;
	localparam logic [1:0] EAU_SZ_WORD = 2'h1;
	localparam logic [1:0] EAU_SZ_LONG = 2'h2;
	localparam logic [31:0] EAU_STEP_B = 32'h1;
	localparam logic [31:0] EAU_STEP_W = 32'h2;
	localparam logic [31:0] EAU_STEP_L = 32'h4;
	// **********
	// extension word fields
	// **********
	localparam int EAU_X_DA = 15; // index is address register
	localparam int EAU_X_LONG = 11; // index taken as long word
	// **********
	// control register selects and reset values
	// **********
	localparam logic [1:0] EAU_CR_VTB = 2'h0; // vector table base
	localparam logic [1:0] EAU_CR_SSC = 2'h1; // source space code
	localparam logic [1:0] EAU_CR_DSC = 2'h2; // dest space code
	localparam logic [31:0] EAU_VTB_RST = 32'h0;
	localparam logic [2:0] EAU_SC_RST = 3'h0;
	// **********
	// normal space codes, built as {supervisor, program, data}
	// **********
	localparam logic [1:0] EAU_SC_DATA = 2'h1;
	localparam logic [1:0] EAU_SC_PROG = 2'h2;
	// **********
	// sequencing states
	// **********
	typedef enum logic [4:0] {
		EAU_IDLE = 5'h01,
		EAU_RBASE = 5'h02,
		EAU_EXTW = 5'h04,
		EAU_RIDX = 5'h08,
		EAU_FIN = 5'h10
	} eau_state_t;
endpackage

// ==== design/eau_spec_decode.sv ====
// operand specifier decoder of the effective address unit
`timescale 1ns/1ps
module eau_spec_decode (
	input wire logic [5:0] spec,
	input wire logic [1:0] size,
	output logic [2:0] mode,
	output logic [2:0] regf,
	output logic [1:0] ext_words,
	output logic invalid
);
	// **********
	// field split and extension count
	// **********
	// all decisions come from the specifier bits and the operand size
	always_comb begin
		mode = spec[5:3]; // see RL8
		regf = spec[2:0]; // see RL8
		invalid = 1'b0;
		ext_words = 2'h0; // see RL6
		case (spec[5:3])
			eau_pkg::EAU_M_DISP, eau_pkg::EAU_M_INDEX: begin
				ext_words = 2'h1; // see RL13 see RL14
			end
			eau_pkg::EAU_M_SPEC: begin
				// sub-mode selected by register field, see RL21 see RL23
				case (spec[2:0])
					eau_pkg::EAU_S_ABSS, eau_pkg::EAU_S_PCD, eau_pkg::EAU_S_PCX: ext_words = 2'h1; // see RL16 see RL18
					eau_pkg::EAU_S_ABSL: ext_words = 2'h2; // see RL17
					eau_pkg::EAU_S_IMM: begin
						// long immediate (code 3 too) takes two words, see RL20
						ext_words = (size != eau_pkg::EAU_SZ_BYTE && size != eau_pkg::EAU_SZ_WORD) ? 2'h2 : 2'h1;
					end
					default: invalid = 1'b1; // see RL25
				endcase
			end
			default: ext_words = 2'h0; // register based, no extension
		endcase
	end
endmodule // eau_spec_decode

// ==== verif/eau_top_asserts.sv ====
// port checker of the effective address unit
`timescale 1ns/1ps
module eau_top_asserts (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic START,
	input wire logic [15:0] OP_WORD,
	input wire logic [1:0] OP_SIZE,
	input wire logic OP_WRITE,
	input wire logic OP_ALT_MOVE,
	input wire logic DONE,
	input wire logic [1:0] EXT_COUNT,
	input wire logic [31:0] EA_ADDR,
	input wire logic EA_IS_REG,
	input wire logic EA_PROGRAM,
	input wire logic EA_INVALID,
	input wire logic EA_MISALIGNED,
	input wire logic LANE_UPPER,
	input wire logic LANE_LOWER,
	input wire logic [2:0] SPACE_CODE,
	input wire logic AN_WB,
	input wire logic [2:0] AN_NUM,
	input wire logic [31:0] AN_NEW,
	input wire logic CREG_WR,
	input wire logic [1:0] CREG_SEL,
	input wire logic [31:0] CREG_WDATA,
	input wire logic [31:0] CREG_RDATA
);
	// **********
	// operation held from take to done
	// **********
	typedef struct packed {
		logic busy;
		logic wr;
		logic alt;
		logic [1:0] sz;
		logic [5:0] spec;
		logic [2:0] dsc;
	} eau_chk_t;
	eau_chk_t s_reg, s_next; // captured operation and dest code shadow
	logic take, mem, pcr;
	logic [31:0] step; // expected register step
	// next state: take in idle or on the done cycle
	always_comb begin
		take = START && (!s_reg.busy || DONE);
		s_next = s_reg;
		if (DONE)
			s_next.busy = 1'b0;
		if (take)
			s_next = {1'b1, OP_WRITE, OP_ALT_MOVE, OP_SIZE, OP_WORD[5:0], s_reg.dsc};
		if (CREG_WR && CREG_SEL == 2'h2)
			s_next.dsc = CREG_WDATA[2:0];
		mem = s_reg.spec[5:4] != 2'h0 && (s_reg.spec[5:3] != 3'h7 || s_reg.spec[2:0] < 3'h4);
		pcr = s_reg.spec inside {6'h3a, 6'h3b};
		step = s_reg.sz == 2'h0 ? (s_reg.spec[2:0] == 3'h7 ? 32'h2 : 32'h1) : s_reg.sz == 2'h1 ? 32'h2 : 32'h4;
	end
	// capture register
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
	// **********
	// properties
	// **********
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!ARST_N);
	sequence s_take_inv;
		take && OP_WORD[5:3] == 3'h7 && OP_WORD[2:0] > 3'h4;
	endsequence
	sequence s_take_short;
		take && OP_WORD[5:3] < 3'h5;
	endsequence
	sequence s_fin_mem;
		DONE && mem;
	endsequence
	chk_invalid_spec: assert property (s_take_inv |=> !DONE ##1 DONE && EA_INVALID && EA_ADDR == 32'h0)
		else $error("invalid spec not flagged");
	chk_short_length: assert property (s_take_short |=> !DONE [*2] ##1 DONE && EXT_COUNT == 2'h0)
		else $error("short spec mis-timed");
	chk_write_data: assert property (DONE && s_reg.wr |-> !EA_PROGRAM)
		else $error("operand write classed as program");
	chk_pc_program: assert property (DONE && pcr && !s_reg.wr |-> EA_PROGRAM)
		else $error("relative reference not program");
	chk_even_access: assert property (s_fin_mem ##0 (s_reg.sz != 2'h0 && EA_ADDR[0]) |-> EA_MISALIGNED)
		else $error("odd word access not flagged");
	chk_byte_lanes: assert property (s_fin_mem ##0 s_reg.sz == 2'h0 |-> LANE_UPPER == !EA_ADDR[0] && LANE_LOWER == EA_ADDR[0])
		else $error("byte lane wrong");
	chk_post_step: assert property (DONE && s_reg.spec[5:3] == 3'h3 |-> AN_WB && AN_NUM == s_reg.spec[2:0] && AN_NEW == EA_ADDR + step)
		else $error("postincrement step wrong");
	chk_pre_step: assert property (DONE && s_reg.spec[5:3] == 3'h4 |-> AN_WB && AN_NEW == EA_ADDR)
		else $error("predecrement address wrong");
	chk_long_count: assert property (DONE && s_reg.spec == 6'h39 |-> EXT_COUNT == 2'h2)
		else $error("abs long count wrong");
	chk_code_width: assert property ((CREG_SEL inside {2'h1, 2'h2}) [*2] |=> CREG_RDATA[31:3] == 29'h0)
		else $error("space code upper bits not zero");
	chk_alt_space: assert property (s_fin_mem ##0 (s_reg.alt && s_reg.wr) |-> SPACE_CODE == s_reg.dsc)
		else $error("alternate write space code wrong");
	chk_reg_direct: assert property (DONE && s_reg.spec[5:4] == 2'h0 |-> EA_IS_REG && EA_ADDR == 32'h0)
		else $error("register direct made an address");
endmodule // eau_top_asserts

// ==== verif/eau_seq_model.sv ====
// far-side model: register file and extension word source
`timescale 1ns/1ps
module eau_seq_model (
	input wire logic sys_clk,
	input wire logic ext_req,
	input wire logic [3:0] rf_sel,
	input wire logic [31:0] rf_base,
	input wire logic [15:0] w0,
	input wire logic [15:0] w1,
	input wire logic [31:0] pc0,
	input wire logic [1:0] gap,
	input wire logic [1:0] nw,
	output logic ext_valid,
	output logic [15:0] ext_word,
	output logic [31:0] ext_pc,
	output logic [31:0] rf_data
);
	int k = 0; // words handed over
	int w = 0; // cycles waited before the next word
	// register read answers at once, settled a cycle after the select
	assign rf_data = rf_base ^ {8{rf_sel}};
	initial begin
		ext_valid = 1'b0;
		ext_word = 16'h0;
		ext_pc = 32'h0;
	end
	// one-cycle word pulses with gap+1 idle cycles between them, only while words are asked for
	always @(posedge sys_clk) begin
		#1;
		if (ext_valid) begin
			ext_valid = 1'b0;
			ext_word = ~ext_word; // stale word does not linger
		end else if (!ext_req) begin
			k = 0;
			w = 0;
		end else if (w < gap) begin
			w++;
		end else if (k < nw) begin
			ext_valid = 1'b1;
			ext_word = k == 0 ? w0 : w1; // high half first
			ext_pc = pc0 + 32'(2 * k); // address of the word itself
			k++;
			w = 0;
		end
	end
endmodule // eau_seq_model

// ==== verif/eau_top_test.sv ====
// self-checking bench of the effective address unit
`timescale 1ns/1ps
module eau_top_test;
	// **********
	// stimulus, observation and counters
	// **********
	logic SYS_CLK = 1'b0, ARST_N = 1'b0, START = 1'b0, CREG_WR = 1'b0;
	logic OP_JUMP = 1'b0, OP_WRITE = 1'b0, OP_ALT_MOVE = 1'b0, OP_STATUS_OK = 1'b0, SUPERVISOR = 1'b0;
	logic [15:0] OP_WORD = 16'h0, w0 = 16'h0, w1 = 16'h0;
	logic [1:0] OP_SIZE = 2'h0, CREG_SEL = 2'h0, gap = 2'h0, nw = 2'h0;
	logic [31:0] CREG_WDATA = 32'h0, rf_base = 32'h0, pc0 = 32'h0;
	logic EXT_REQ, EXT_VALID, DONE, EA_IS_REG, EA_IS_IMM, EA_STATUS, EA_PROGRAM, EA_INVALID, EA_MISALIGNED;
	logic LANE_UPPER, LANE_LOWER, AN_WB;
	logic [15:0] EXT_WORD;
	logic [31:0] EXT_PC, RF_DATA, EA_ADDR, EA_DATA, AN_NEW, CREG_RDATA;
	logic [3:0] RF_SEL;
	logic [1:0] EXT_COUNT;
	logic [2:0] SPACE_CODE, AN_NUM, ssc = 3'h0, dsc = 3'h0;
	int seed = 82;
	int error_cnt = 0;
	int check_count = 0;
	always #4 SYS_CLK = ~SYS_CLK;
	eau_top eau_top_inst (.SYS_CLK, .ARST_N, .START, .OP_WORD, .OP_SIZE, .OP_JUMP, .OP_WRITE, .OP_ALT_MOVE,
		.OP_STATUS_OK, .SUPERVISOR, .EXT_REQ, .EXT_VALID, .EXT_WORD, .EXT_PC, .RF_SEL, .RF_DATA, .DONE, .EXT_COUNT,
		.EA_ADDR, .EA_DATA, .EA_IS_REG, .EA_IS_IMM, .EA_STATUS, .EA_PROGRAM, .EA_INVALID, .EA_MISALIGNED,
		.LANE_UPPER, .LANE_LOWER, .SPACE_CODE, .AN_WB, .AN_NUM, .AN_NEW, .CREG_WR, .CREG_SEL, .CREG_WDATA, .CREG_RDATA);
	eau_seq_model eau_seq_model_inst (.sys_clk(SYS_CLK), .ext_req(EXT_REQ), .rf_sel(RF_SEL), .rf_base, .w0, .w1,
		.pc0, .gap, .nw, .ext_valid(EXT_VALID), .ext_word(EXT_WORD), .ext_pc(EXT_PC), .rf_data(RF_DATA));
	// **********
	// shared tasks
	// **********
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// register file contents as the model holds them
	function automatic logic [31:0] rfv(input logic [3:0] s);
		return rf_base ^ {8{s}};
	endfunction
	// control register access, read back two cycles on
	task automatic creg(input logic [1:0] sel, input logic wr, input logic [31:0] d);
		@(posedge SYS_CLK);
		#1;
		CREG_SEL = sel;
		CREG_WR = wr;
		CREG_WDATA = d;
		@(posedge SYS_CLK);
		#1;
		CREG_WR = 1'b0;
		repeat (2) @(posedge SYS_CLK);
		#1;
	endtask
	// one specifier: draw values, work out the result, run, compare
	task automatic run_op(input logic [5:0] spec, input logic [1:0] sz);
		logic [2:0] m, r, mm;
		logic [31:0] a, x, ea, st, dat, msk;
		logic mem, inv, imm, prog;
		logic [1:0] nx, ln;
		int i;
		@(posedge SYS_CLK);
		#1;
		{w0, w1, rf_base} = {$random(seed), $random(seed)};
		pc0 = $random(seed) & 32'hffff_fffe;
		{gap, SUPERVISOR, OP_JUMP, OP_WRITE, OP_ALT_MOVE, OP_STATUS_OK} = 7'($random(seed));
		m = spec[5:3];
		r = spec[2:0];
		inv = m == 3'h7 && r > 3'h4;
		imm = m == 3'h7 && r == 3'h4;
		mem = m > 3'h1 && !(m == 3'h7 && r > 3'h3);
		nx = inv || m < 3'h5 ? 2'h0 : r == 3'h1 && m == 3'h7 || imm && sz[1] ? 2'h2 : 2'h1;
		mm = m == 3'h7 && r == 3'h2 ? 3'h5 : m == 3'h7 && r == 3'h3 ? 3'h6 : m;
		a = m == 3'h7 ? pc0 : rfv({1'b1, r});
		x = rfv(w0[15:12]);
		x = w0[11] ? x : {{16{x[15]}}, x[15:0]};
		st = sz == 2'h0 ? (r == 3'h7 ? 32'h2 : 32'h1) : sz == 2'h1 ? 32'h2 : 32'h4;
		case (mm)
			3'h4: ea = a - st;
			3'h5: ea = a + {{16{w0[15]}}, w0};
			3'h6: ea = a + {{24{w0[7]}}, w0[7:0]} + x;
			3'h7: ea = r == 3'h0 ? {{16{w0[15]}}, w0} : {w0, w1};
			default: ea = a;
		endcase
		prog = !OP_WRITE && (mm != m || OP_JUMP && mem);
		ln = sz == 2'h0 ? {!(mem && ea[0]), mem && ea[0]} : {2{mem}};
		dat = m == 3'h7 ? (sz[1] ? {w0, w1} : {16'h0, w0}) : m == 3'h0 ? rfv({1'b0, r}) : sz == 2'h1 ? {{16{a[15]}}, a[15:0]} : a;
		msk = m == 3'h1 && sz == 2'h1 || sz[1] ? 32'hffff_ffff : sz == 2'h0 ? 32'hff : 32'hffff;
		nw = nx;
		OP_WORD = {w1[9:0], spec};
		OP_SIZE = sz;
		START = 1'b1;
		@(posedge SYS_CLK);
		#1;
		START = 1'b0;
		for (i = 0; i < 40 && DONE !== 1'b1; i++) begin
			@(posedge SYS_CLK);
			#1;
		end
		check(i < 40, 1'b1);
		check({EA_IS_REG, EA_IS_IMM, EA_STATUS, EA_INVALID, EXT_COUNT}, {m < 3'h2, imm && !OP_STATUS_OK, imm && OP_STATUS_OK, inv, nx});
		check(EA_ADDR, mem ? ea : 32'h0);
		check({EA_PROGRAM, EA_MISALIGNED, LANE_UPPER, LANE_LOWER}, {prog, mem && sz != 2'h0 && ea[0], ln});
		if (mem)
			check(SPACE_CODE, OP_ALT_MOVE ? (OP_WRITE ? dsc : ssc) : {SUPERVISOR, prog ? 2'h2 : 2'h1});
		if (!mem && !inv)
			check(EA_DATA & msk, dat & msk);
		check(AN_WB, m == 3'h3 || m == 3'h4);
		if (m == 3'h3 || m == 3'h4)
			check(AN_NEW, m == 3'h3 ? a + st : ea);
	endtask
	// **********
	// main sequence and watchdog
	// **********
	initial begin
		repeat (5) @(posedge SYS_CLK);
		#1;
		ARST_N = 1'b1;
		repeat (3) @(posedge SYS_CLK);
		for (int i = 0; i < 4; i++) begin
			creg(i[1:0], 1'b0, 32'h0);
			check(CREG_RDATA, 32'h0);
		end
		for (int i = 0; i < 4; i++) begin
			creg(i[1:0], 1'b1, $random(seed));
			check(CREG_RDATA, i == 0 ? CREG_WDATA : i == 3 ? 32'h0 : {29'h0, CREG_WDATA[2:0]});
			ssc = i == 1 ? CREG_WDATA[2:0] : ssc;
			dsc = i == 2 ? CREG_WDATA[2:0] : dsc;
		end
		$display("control register test done");
		for (int s = 0; s < 64; s++)
			for (int z = 0; z < 4; z++)
				run_op(s[5:0], z[1:0]);
		$display("specifier sweep done");
		repeat (100) run_op(6'($random(seed)), 2'($random(seed)));
		$display("random test done");
		finish_test();
	end
	initial begin
		#400000;
		error_cnt++;
		finish_test();
	end
endmodule // eau_top_test
bind eau_top eau_top_asserts eau_top_asserts_inst (.SYS_CLK, .ARST_N, .START, .OP_WORD, .OP_SIZE, .OP_WRITE,
	.OP_ALT_MOVE, .DONE, .EXT_COUNT, .EA_ADDR, .EA_IS_REG, .EA_PROGRAM, .EA_INVALID, .EA_MISALIGNED, .LANE_UPPER,
	.LANE_LOWER, .SPACE_CODE, .AN_WB, .AN_NUM, .AN_NEW, .CREG_WR, .CREG_SEL, .CREG_WDATA, .CREG_RDATA);
